// ===== hw/dps_top.sv
// drive power state automaton with APB registers
// Functional notes
// - leave start state, self-diagnose after reset
// - enter switch-on-disabled when init completes
// - shutdown accepted only without safe torque off
// - servo ready and switch-on need main power
// - safe torque off forces switch-on-disabled from ready, switched-on, operation and quick stop
// - enable operation from switched-on enables drive, clears set-points
// - disable operation returns to switched-on
// - switched-on drops on shutdown or power off
// - ready/switched-on disable on voltage, qstop, bus, torque
// - shutdown in operation goes to ready; the code also requires main power on
// - operation disables on voltage, torque, abort code 2
// - quick stop on command or abort code 3
// - quick stop exits to switch-on-disabled, four cases
// - fault reaction on error, abort code 1, retract
// - fault reaction done leads to fault
// - fault reset only when no cause remains
// - enable operation resumes from quick stop codes 5-7
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
module dps_top import dps_pkg::*; #(
  parameter int INIT_CYCLES = INIT_CYC, // self-diagnosis length
  parameter int SERVO_WAIT = SERVO_CYC, // servo-on settle count
  parameter int QSTOP_CYCLES = 64, // quick stop deceleration length
  parameter int FREACT_CYCLES = 64 // fault deceleration length
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous condition pins
  input wire logic mainPowerOn,
  input wire logic safeTorqueOff,
  input wire logic busStateDrop,
  input wire logic errorDetect,
  input wire logic retractTrigger,
  // drive side
  output logic driveEnable,
  output logic quickStopRun,
  output logic faultReactRun,
  output logic retractRun,
  output logic setpointClear,
  output logic servoReady,
  output logic servoSettled
);
  // ===========================================================
  // declarations
  dps_state_t stateQ; // automaton state
  dps_state_t stateD; // next state
  dps_cond_t cond; // synchronised pins
  dps_cmd_t cmd; // decoded control word
  logic [15:0] ctrlQ; // control word register
  logic ctrlNewQ; // control word written, one cycle
  logic [3:0] abortQ; // abort-connection option code
  logic [3:0] qstopQ; // quick stop option code
  logic causeQ; // sticky fault cause
  logic mainPowerQ; // power level one cycle ago
  logic powerOff; // falling edge of main power
  logic [31:0] cntQ; // shared timer for timed states
  logic timerDone; // current timed phase finished
  logic qsDoneQ; // quick stop deceleration finished
  logic retractQ; // fault reaction runs retract
  logic spClearQ; // set-point clear pulse
  logic [31:0] settleQ; // servo-on settle counter
  logic wrEn; // apb write strobe
  logic rdEn; // apb read strobe
  logic mapped; // address hits a register
  logic causeClr; // software clears fault cause
  // ===========================================================
  // input synchronisation
  dps_sync #(.WIDTH(5)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din({mainPowerOn, safeTorqueOff, busStateDrop, errorDetect,
          retractTrigger}),
    .dout(cond)
  );
  // command decoding
  dps_cmd_dec u_dec (
    .ctrlWord(ctrlQ),
    .cmd(cmd)
  );
  // ===========================================================
  // apb decode
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == CTRL_OFF) || (a == STAT_OFF) || (a == OPT_OFF) ||
               (a == CAUSE_OFF);
  endfunction
  assign pready = 1'b1; // zero wait states
  assign mapped = isMapped(paddr);
  assign pslverr = psel && penable && !mapped; // unmapped answer
  assign wrEn = psel && penable && pwrite && mapped;
  assign rdEn = psel && !penable && !pwrite; // setup cycle
  assign causeClr = wrEn && (paddr == CAUSE_OFF) && pwdata[0];
  // control and option registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlQ <= 16'h0000;
      ctrlNewQ <= 1'b0;
      abortQ <= ABORT_RST;
      qstopQ <= QSTOP_RST;
    end else begin
      ctrlNewQ <= wrEn && (paddr == CTRL_OFF);
      if (wrEn && (paddr == CTRL_OFF)) begin
        ctrlQ <= pwdata[15:0];
      end
      if (wrEn && (paddr == OPT_OFF)) begin
        abortQ <= pwdata[OPT_ABORT_LSB +: 4];
        qstopQ <= pwdata[OPT_QSTOP_LSB +: 4];
      end
    end
  end
  // read data, registered in the setup cycle so it stands at the access
  // edge; status is one cycle old then, harmless for a polling master
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      prdata <= 32'h0000_0000;
      case (paddr)
        CTRL_OFF: prdata[15:0] <= ctrlQ;
        STAT_OFF: begin
          prdata[ST_STATE_LSB +: 4] <= stateQ;
          prdata[ST_DRIVE] <= driveEnable;
          prdata[ST_RDY] <= servoReady;
          prdata[ST_SPCLR] <= spClearQ;
          prdata[ST_QSRUN] <= quickStopRun;
          prdata[ST_FRRUN] <= faultReactRun;
          prdata[ST_RETR] <= retractQ;
          prdata[ST_CAUSE] <= causeQ;
        end
        OPT_OFF: begin
          prdata[OPT_ABORT_LSB +: 4] <= abortQ;
          prdata[OPT_QSTOP_LSB +: 4] <= qstopQ;
        end
        CAUSE_OFF: prdata[0] <= causeQ;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // ===========================================================
  // condition tracking
  assign powerOff = mainPowerQ && !cond.mainPower;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mainPowerQ <= 1'b0;
    end else begin
      mainPowerQ <= cond.mainPower;
    end
  end
  // sticky fault cause: a new error wins over a clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      causeQ <= 1'b0;
    end else if (cond.errorSeen) begin
      causeQ <= 1'b1;
    end else if (causeClr) begin
      causeQ <= 1'b0;
    end
  end
  // ===========================================================
  // timer for init, quick stop and fault reaction phases
  always_comb begin
    case (stateQ)
      ST_INIT: timerDone = (cntQ >= 32'(INIT_CYCLES - 1));
      ST_QSA: timerDone = (cntQ >= 32'(QSTOP_CYCLES - 1));
      ST_FRA: timerDone = (cntQ >= 32'(FREACT_CYCLES - 1));
      default: timerDone = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cntQ <= 32'h0000_0000;
    end else if (stateD != stateQ || timerDone) begin
      cntQ <= 32'h0000_0000; // restart per phase
    end else begin
      cntQ <= cntQ + 32'h0000_0001;
    end
  end
  // quick stop completion flag, held while in quick stop
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      qsDoneQ <= 1'b0;
    end else if (stateQ != ST_QSA) begin
      qsDoneQ <= 1'b0;
    end else if (timerDone) begin
      qsDoneQ <= 1'b1;
    end
  end
  // ===========================================================
  // next-state logic; commands act once per control word write
  always_comb begin
    stateD = stateQ;
    case (stateQ)
      ST_START: stateD = ST_INIT;
      ST_INIT: if (timerDone) stateD = ST_SOD;
      ST_SOD: begin
        if (ctrlNewQ && cmd.shutdown && !cond.safeTorqueOff) begin
          stateD = ST_RDYSO;
        end
      end
      ST_RDYSO: begin
        if (cond.safeTorqueOff || cond.busDrop ||
            (ctrlNewQ && (cmd.disableVolt || cmd.quickStop))) begin
          stateD = ST_SOD;
        end else if (ctrlNewQ && cmd.switchOn && cond.mainPower) begin
          stateD = ST_SWON;
        end
      end
      ST_SWON: begin
        if (cond.safeTorqueOff || cond.busDrop ||
            (ctrlNewQ && (cmd.disableVolt || cmd.quickStop))) begin
          stateD = ST_SOD;
        end else if (powerOff || !cond.mainPower ||
                     (ctrlNewQ && cmd.shutdown)) begin
          stateD = ST_RDYSO;
        end else if (ctrlNewQ && cmd.enableOp) begin
          stateD = ST_OPEN;
        end
      end
      ST_OPEN: begin
        if (cond.errorSeen || cond.retractTrig ||
            (powerOff && abortQ == 4'h1)) begin
          stateD = ST_FRA;
        end else if (cond.safeTorqueOff ||
                     (ctrlNewQ && cmd.disableVolt) ||
                     (powerOff && abortQ == 4'h2)) begin
          stateD = ST_SOD;
        end else if ((ctrlNewQ && cmd.quickStop) ||
                     (powerOff && abortQ == 4'h3)) begin
          stateD = ST_QSA;
        end else if (ctrlNewQ && cmd.shutdown && cond.mainPower) begin
          stateD = ST_RDYSO;
        end else if (ctrlNewQ && cmd.disableOp) begin
          stateD = ST_SWON;
        end
      end
      ST_QSA: begin
        if (cond.errorSeen || cond.retractTrig) begin
          stateD = ST_FRA;
        end else if (cond.safeTorqueOff || powerOff ||
                     (timerDone && qstopQ >= 4'h1 && qstopQ <= 4'h3) ||
                     (qsDoneQ && ctrlNewQ && cmd.disableVolt &&
                      qstopQ >= 4'h5 && qstopQ <= 4'h7)) begin
          stateD = ST_SOD;
        end else if (ctrlNewQ && cmd.enableOp &&
                     qstopQ >= 4'h5 && qstopQ <= 4'h7) begin
          stateD = ST_OPEN;
        end
      end
      ST_FRA: if (timerDone) stateD = ST_FAULT;
      ST_FAULT: begin
        if (ctrlNewQ && cmd.faultReset && !causeQ &&
            !cond.errorSeen) begin
          stateD = ST_SOD;
        end
      end
      default: stateD = ST_START;
    endcase
    // torque off overrides the ready-to-switch-on and switched-on states
    if (cond.safeTorqueOff && (stateQ == ST_RDYSO ||
        stateQ == ST_SWON)) begin
      stateD = ST_SOD;
    end
  end
  // state register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= ST_START;
    end else begin
      stateQ <= stateD;
    end
  end
  // ===========================================================
  // drive outputs, registered from the next state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      driveEnable <= 1'b0;
      quickStopRun <= 1'b0;
      faultReactRun <= 1'b0;
      spClearQ <= 1'b0;
    end else begin
      driveEnable <= (stateD == ST_OPEN) || (stateD == ST_QSA) ||
                     (stateD == ST_FRA);
      quickStopRun <= (stateD == ST_QSA) && !qsDoneQ;
      faultReactRun <= (stateD == ST_FRA);
      spClearQ <= (stateQ == ST_SWON) && (stateD == ST_OPEN);
    end
  end
  // retract flag for the fault reaction in progress
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      retractQ <= 1'b0;
    end else if (stateD != ST_FRA) begin
      retractQ <= 1'b0;
    end else if (stateQ != ST_FRA && cond.retractTrig) begin
      retractQ <= 1'b1;
    end
  end
  // servo ready follows main power while torque is on, outside start-up and fault
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      servoReady <= 1'b0;
    end else begin
      servoReady <= cond.mainPower && !cond.safeTorqueOff &&
                    stateQ != ST_START && stateQ != ST_INIT &&
                    stateQ != ST_FAULT && stateQ != ST_FRA;
    end
  end
  // settle indication: master may issue motion after this rises
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      settleQ <= 32'h0000_0000;
      servoSettled <= 1'b0;
    end else if (stateQ != ST_OPEN) begin
      settleQ <= 32'h0000_0000;
      servoSettled <= 1'b0;
    end else if (settleQ >= 32'(SERVO_WAIT - 1)) begin
      servoSettled <= 1'b1;
    end else begin
      settleQ <= settleQ + 32'h0000_0001;
    end
  end
  assign retractRun = retractQ;
  assign setpointClear = spClearQ;
endmodule

// ===== hw/dps_pkg.sv
// package: states, register map, field positions and timing for the drive state block
package dps_pkg;
  // ===========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [11:0] CTRL_OFF = 12'h000; // control word
  localparam logic [11:0] STAT_OFF = 12'h004; // status word
  localparam logic [11:0] OPT_OFF = 12'h008; // option codes
  localparam logic [11:0] CAUSE_OFF = 12'h00C; // fault cause / clear
  // ===========================================================
  // control word bit positions
  localparam int CW_SO = 0; // switch on
  localparam int CW_EV = 1; // enable voltage
  localparam int CW_QS = 2; // quick stop, active low
  localparam int CW_EO = 3; // enable operation
  localparam int CW_FR = 7; // fault reset
  // ===========================================================
  // option register field positions
  localparam int OPT_ABORT_LSB = 0; // abort-connection code, 4 bits
  localparam int OPT_QSTOP_LSB = 8; // quick stop code, 4 bits
  localparam logic [3:0] ABORT_RST = 4'h1; // reset value
  localparam logic [3:0] QSTOP_RST = 4'h2; // reset value
  // ===========================================================
  // status register field positions
  localparam int ST_STATE_LSB = 0; // state code, 4 bits
  localparam int ST_DRIVE = 4; // drive functions on
  localparam int ST_RDY = 5; // servo ready
  localparam int ST_SPCLR = 6; // set-point clear pulse seen
  localparam int ST_QSRUN = 7; // quick stop function running
  localparam int ST_FRRUN = 8; // fault reaction running
  localparam int ST_RETR = 9; // retract running
  localparam int ST_CAUSE = 10; // fault cause latched
  // ===========================================================
  // timing
  localparam int CLK_MHZ = 100; // ref_clk rate
  localparam int INIT_US = 10; // self-diagnosis length
  localparam int INIT_CYC = INIT_US * CLK_MHZ; // cycles
  localparam int SERVO_MS = 100; // master wait after servo on
  localparam int SERVO_CYC = SERVO_MS * 1000 * CLK_MHZ; // cycles
  // ===========================================================
  typedef enum logic [3:0] {
    ST_START, ST_INIT, ST_SOD, ST_RDYSO, ST_SWON, ST_OPEN, ST_QSA,
    ST_FRA, ST_FAULT
  } dps_state_t;
  // decoded master command
  typedef struct packed {
    logic shutdown;
    logic switchOn;
    logic enableOp;
    logic disableVolt;
    logic quickStop;
    logic disableOp;
    logic faultReset;
  } dps_cmd_t;
  // condition inputs after synchronisation
  typedef struct packed {
    logic mainPower;
    logic safeTorqueOff;
    logic busDrop;
    logic errorSeen;
    logic retractTrig;
  } dps_cond_t;
endpackage

// ===== hw/dps_sync.sv
// three-flop synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module dps_sync import dps_pkg::*; #(
  parameter int WIDTH = 5
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // ===========================================================
  // stages
  logic [WIDTH-1:0] s1Q; // first stage, read only by s2Q
  logic [WIDTH-1:0] s2Q; // second stage
  logic [WIDTH-1:0] s3Q; // third stage
  // shift chain
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1Q <= '0;
      s2Q <= '0;
      s3Q <= '0;
    end else begin
      s1Q <= din;
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end
  // filter: output moves per bit only when two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          dout[i] <= 1'b0;
        end else if (s2Q[i] == s3Q[i]) begin
          dout[i] <= s3Q[i];
        end
      end
    end
  endgenerate
endmodule

// ===== hw/dps_cmd_dec.sv
// decoder from the control word to drive commands
`timescale 1ns/100ps
module dps_cmd_dec import dps_pkg::*; (
  input wire logic [15:0] ctrlWord,
  output dps_cmd_t cmd
);
  // ===========================================================
  // command patterns on bits 7,3,2,1,0
  always_comb begin
    cmd = '0;
    if (ctrlWord[CW_FR]) begin
      cmd.faultReset = 1'b1; // fault reset dominates
    end else if (!ctrlWord[CW_EV]) begin
      cmd.disableVolt = 1'b1;
    end else if (!ctrlWord[CW_QS]) begin
      cmd.quickStop = 1'b1; // inverted sense bit
    end else if (!ctrlWord[CW_SO]) begin
      cmd.shutdown = 1'b1;
    end else if (ctrlWord[CW_EO]) begin
      cmd.enableOp = 1'b1;
    end else begin
      cmd.switchOn = 1'b1; // same code as disable operation
      cmd.disableOp = 1'b1;
    end
  end
endmodule

// ===== dv/dps_top_chk.sv
// port-level assertions for the drive power state block
`timescale 1ns/100ps
module dps_top_chk import dps_pkg::*; (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mainPowerOn,
  input wire logic safeTorqueOff,
  input wire logic errorDetect,
  input wire logic driveEnable,
  input wire logic quickStopRun,
  input wire logic faultReactRun,
  input wire logic retractRun,
  input wire logic setpointClear,
  input wire logic servoReady
);
  // ======
  // helper counters, saturating at 15
  logic [3:0] offCntQ; // cycles without main power
  logic [3:0] tqOffCntQ; // cycles with torque off held
  logic mapped; // address hits one of the four words
  assign mapped = paddr inside {CTRL_OFF, STAT_OFF, OPT_OFF, CAUSE_OFF};
  // counts past the pin synchroniser latency before judging
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      offCntQ <= 4'h0;
    end else begin
      offCntQ <= mainPowerOn ? 4'h0 : offCntQ + {3'h0, offCntQ != 4'hf};
    end
  end
  // same for the torque-off pin
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tqOffCntQ <= 4'h0;
    end else begin
      tqOffCntQ <= !safeTorqueOff ? 4'h0 :
          tqOffCntQ + {3'h0, tqOffCntQ != 4'hf};
    end
  end
  // ======
  // properties
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  // fault reaction holds, then ends with drive off
  sequence s_react;
    faultReactRun [*6];
  endsequence
  sequence s_end;
    !faultReactRun ##[0:1] !driveEnable;
  endsequence
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  chk_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_ready_power: assert property (offCntQ >= 4'ha |-> !servoReady)
    else $error("servo ready without main power");
  chk_torque_off: assert property (tqOffCntQ >= 4'ha |-> !driveEnable || faultReactRun)
    else $error("drive on under torque off");
  chk_setpoint_drive: assert property (setpointClear |-> ##[0:1] driveEnable)
    else $error("set-point clear without drive on");
  chk_setpoint_pulse: assert property (setpointClear |=> !setpointClear)
    else $error("set-point clear longer than one cycle");
  chk_qstop_drive: assert property (quickStopRun |-> driveEnable)
    else $error("quick stop without drive functions");
  chk_retract_react: assert property (retractRun |-> faultReactRun)
    else $error("retract outside fault reaction");
  chk_error_react: assert property (errorDetect [*8] |-> faultReactRun || !driveEnable)
    else $error("error left drive running");
  chk_react_done: assert property ($rose(faultReactRun) |-> s_react ##[0:8] s_end)
    else $error("fault reaction did not end in drive off");
endmodule

// ===== dv/dps_master.sv
// bus master model standing in for the fieldbus controller
`timescale 1ns/100ps
module dps_master import dps_pkg::*; (
  input wire logic ref_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ======
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // one transfer; request held until ready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic err,
      output logic ok);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ok = pready === 1'b1;
    err = pslverr;
    r = prdata; // taken at the edge that completes the access
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep showing the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // next command only after status shows the state, bounded
  task automatic waitState(input logic [3:0] s, output logic [31:0] r,
      output logic ok);
    logic e;
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      xfer(1'b0, STAT_OFF, 32'h0000_0000, r, e, ok);
      ok = ok && r[3:0] == s;
    end
  endtask
endmodule

// ===== dv/tb_drive_power_state_machine.sv
// self-checking bench for the drive power state block
`timescale 1ns/100ps
module tb_drive_power_state_machine;
  import dps_pkg::*;
  // ======
  // commands on bits 7,3,2,1,0; pins {power,torque,bus,error,retract}
  localparam logic [15:0] SHUT = 16'h0006;
  localparam logic [15:0] SWON = 16'h0007;
  localparam logic [15:0] ENOP = 16'h000f;
  localparam logic [15:0] DVOLT = 16'h0000;
  localparam logic [15:0] QSTOP = 16'h0002;
  localparam logic [15:0] FRST = 16'h0080;
  localparam logic [4:0] PWR = 5'h10, TQOFF = 5'h08, BUS = 5'h04;
  localparam logic [4:0] ERR = 5'h02, RET = 5'h01;
  localparam int SETTLE = 40; // shortened servo-on settle count
  // ======
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic mainPowerOn = 1'b0, safeTorqueOff = 1'b0, busStateDrop = 1'b0;
  logic errorDetect = 1'b0, retractTrigger = 1'b0;
  logic driveEnable, quickStopRun, faultReactRun, retractRun;
  logic setpointClear, servoReady, servoSettled;
  logic [3:0] saw = 4'h0; // {quick stop, reaction, retract, clear} seen
  int failures = 0;
  int comparisons = 0;
  dps_state_t st = ST_START; // model state
  int qsc = 2; // model quick stop code
  bit causeM = 1'b0, tqOffM = 1'b0, pwrM = 1'b0; // model conditions
  initial forever #5 ref_clk = ~ref_clk;
  // short pulses are caught here so slow polling cannot miss them
  always @(posedge ref_clk) saw <= saw | {quickStopRun === 1'b1,
      faultReactRun === 1'b1, retractRun === 1'b1, setpointClear === 1'b1};
  dps_top #(.INIT_CYCLES(20), .SERVO_WAIT(SETTLE), .QSTOP_CYCLES(8),
      .FREACT_CYCLES(8)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mainPowerOn(mainPowerOn),
      .safeTorqueOff(safeTorqueOff), .busStateDrop(busStateDrop),
      .errorDetect(errorDetect), .retractTrigger(retractTrigger),
      .driveEnable(driveEnable), .quickStopRun(quickStopRun),
      .faultReactRun(faultReactRun), .retractRun(retractRun),
      .setpointClear(setpointClear), .servoReady(servoReady),
      .servoSettled(servoSettled));
  dps_master m (.ref_clk(ref_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
  // ======
  // verdict and comparison
  task automatic stop_test;
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // command reaction of the automaton, conditions from model flags
  function automatic dps_state_t model(dps_state_t s, logic [15:0] c);
    if (c[CW_FR]) return (s == ST_FAULT && !causeM) ? ST_SOD : s;
    if (!c[CW_EV]) return (s inside {ST_RDYSO, ST_SWON, ST_OPEN} ||
        (s == ST_QSA && qsc >= 5)) ? ST_SOD : s;
    if (!c[CW_QS]) return s == ST_OPEN ? ST_QSA :
        s inside {ST_RDYSO, ST_SWON} ? ST_SOD : s;
    if (!c[CW_SO]) return (s == ST_SOD && !tqOffM) ||
        s inside {ST_SWON, ST_OPEN} ? ST_RDYSO : s;
    if (!c[CW_EO]) return (s == ST_RDYSO && pwrM) || s == ST_OPEN ?
        ST_SWON : s;
    return s == ST_SWON || (s == ST_QSA && qsc >= 5) ? ST_OPEN : s;
  endfunction
  // ======
  // bus, command and pin helpers
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    logic ok;
    m.xfer(w, a, d, rdat, rerr, ok);
    if (!ok) begin
      failures++;
      stop_test;
    end
  endtask
  task automatic settle;
    logic [31:0] r;
    logic ok;
    repeat (12) @(posedge ref_clk);
    m.waitState(st, r, ok);
    check(r[3:0], st);
    if (!ok) stop_test;
  endtask
  task automatic cmd(input logic [15:0] cw);
    st = model(st, cw);
    if (st == ST_QSA && qsc < 5) st = ST_SOD; // quick stop ends alone
    bus(1'b1, CTRL_OFF, {16'h0000, cw | 16'($urandom & 32'h0000_0070)});
    settle;
  endtask
  task automatic pins(input logic [4:0] v, input dps_state_t s);
    @(posedge ref_clk);
    {mainPowerOn, safeTorqueOff, busStateDrop, errorDetect,
        retractTrigger} <= v;
    pwrM = v[4];
    tqOffM = v[3];
    st = s;
    settle;
  endtask
  task automatic toOp;
    @(negedge ref_clk) saw = 4'h0; // off the edge the monitor uses
    cmd(SHUT);
    cmd(SWON);
    cmd(ENOP);
  endtask
  task automatic clearFault;
    bus(1'b1, CAUSE_OFF, 32'h0000_0001);
    bus(1'b0, CAUSE_OFF, 32'h0000_0000);
    check(rdat[0], 1'b0);
    causeM = 1'b0;
    cmd(FRST);
  endtask
  // ======
  // main sequence
  initial begin
    int n;
    void'($urandom(32'hd53f_8aa8));
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    st = ST_SOD;
    settle;
    bus(1'b0, OPT_OFF, 32'h0000_0000);
    check(rdat, {20'h0_0000, QSTOP_RST, 4'h0, ABORT_RST});
    bus(1'b0, 12'h010, 32'h0000_0000);
    check(rerr, 1'b1);
    bus(1'b1, STAT_OFF, 32'h0000_000f);
    settle;
    pins(TQOFF, ST_SOD);
    cmd(SHUT);
    pins(TQOFF | PWR, ST_SOD);
    pins(5'h00, ST_SOD);
    cmd(SHUT);
    cmd(SWON);
    check(servoReady, 1'b0);
    pins(TQOFF, ST_SOD);
    pins(PWR, ST_SOD);
    cmd(SHUT);
    cmd(SWON);
    check(servoReady, 1'b1);
    cmd(SHUT);
    cmd(SWON);
    pins(5'h00, ST_RDYSO);
    pins(PWR, ST_RDYSO);
    cmd(SWON);
    pins(PWR | BUS, ST_SOD);
    pins(PWR, ST_SOD);
    for (int i = 0; i < 4; i++) begin
      cmd(SHUT);
      if (i[0]) cmd(SWON);
      cmd(i[1] ? QSTOP : DVOLT);
    end
    toOp;
    check(driveEnable, 1'b1);
    check(saw[0], 1'b1);
    check(servoSettled, 1'b0);
    for (n = 0; servoSettled !== 1'b1 && n < SETTLE + 20; n++) begin
      @(posedge ref_clk);
    end
    check(servoSettled, 1'b1);
    cmd(SWON);
    check(driveEnable, 1'b0);
    cmd(ENOP);
    cmd(SHUT);
    check(driveEnable, 1'b0);
    cmd(SWON);
    cmd(ENOP);
    cmd(DVOLT);
    qsc = 5;
    bus(1'b1, OPT_OFF, 32'h0000_0501);
    for (int i = 0; i < 2; i++) begin
      toOp;
      if (i == 1) cmd(QSTOP);
      pins(PWR | TQOFF, ST_SOD);
      pins(PWR, ST_SOD);
    end
    toOp;
    cmd(QSTOP);
    cmd(ENOP);
    check(driveEnable, 1'b1);
    cmd(QSTOP);
    check(quickStopRun, 1'b0);
    cmd(DVOLT);
    qsc = 2;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OPT_OFF, 32'h0000_0200 | 32'(c));
      toOp;
      cmd(c == 3 ? QSTOP : ENOP);
      check(saw[3], c == 3);
      if (c == 3) toOp;
      pins(5'h00, c == 1 ? ST_FAULT : c == 0 ? ST_OPEN : ST_SOD);
      pins(PWR, st);
      if (c == 0) cmd(DVOLT);
      if (c == 1) clearFault;
    end
    toOp;
    pins(PWR | ERR, ST_FAULT);
    check(saw[2], 1'b1);
    check(driveEnable, 1'b0);
    pins(PWR, ST_FAULT);
    causeM = 1'b1;
    cmd(FRST);
    clearFault;
    toOp;
    pins(PWR | RET, ST_FAULT);
    check(saw[1], 1'b1);
    pins(PWR, ST_FAULT);
    clearFault;
    stop_test;
  end
endmodule
bind dps_top dps_top_chk chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .mainPowerOn(mainPowerOn),
  .safeTorqueOff(safeTorqueOff), .errorDetect(errorDetect),
  .driveEnable(driveEnable), .quickStopRun(quickStopRun),
  .faultReactRun(faultReactRun), .retractRun(retractRun),
  .setpointClear(setpointClear), .servoReady(servoReady));
